//--- rtl/slm_defs.vh
// Constants for the sum-of-products logic array and its macrocells.
// Assumes inclusion by the array top, the macrocell module, the checker and the bench.
`ifndef SLM_DEFS_VH
`define SLM_DEFS_VH

// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define SLM_DED_SMALL      4
`define SLM_IO_SMALL       16
`define SLM_PT_PER_MC      10
`define SLM_SUM_TERMS      8
`define SLM_PT_CLEAR       8
`define SLM_PT_OECLK       9
`define SLM_CFG_W          16

// ----------------------------------------------------------------------
// Per-cell configuration word fields
// ----------------------------------------------------------------------
`define SLM_CFG_TYPE_LSB   0
`define SLM_CFG_OSEL_LSB   2
`define SLM_CFG_FSEL_LSB   4
`define SLM_CFG_INV_BIT    6
`define SLM_CFG_OINV_BIT   7
`define SLM_CFG_MODE_BIT   8
`define SLM_CFG_SPLIT_LSB  8

// Register types.
`define SLM_TYPE_D         2'h0
`define SLM_TYPE_T         2'h1
`define SLM_TYPE_JK        2'h2
`define SLM_TYPE_SR        2'h3

// Output select.
`define SLM_OSEL_NONE      2'h0
`define SLM_OSEL_COMB      2'h1
`define SLM_OSEL_REG       2'h2

// Feedback select.
`define SLM_FSEL_PIN       2'h0
`define SLM_FSEL_REG       2'h1
`define SLM_FSEL_COMB      2'h2
`define SLM_FSEL_NONE      2'h3

// ----------------------------------------------------------------------
// Register map, byte addresses
// ----------------------------------------------------------------------
`define SLM_ADR_CTRL       8'h00
`define SLM_ADR_PIN_IN     8'h04
`define SLM_ADR_DED_IN     8'h08
`define SLM_ADR_REG_STATE  8'h0c
`define SLM_ADR_CFG_INDEX  8'h10
`define SLM_ADR_CFG_DATA   8'h14
`define SLM_ADR_MASK_DATA  8'h18
`define SLM_ADR_STATUS     8'h1c

`define SLM_CTRL_RESET     1'h0
`define SLM_INDEX_RESET    16'h0000

`endif

//--- rtl/slm_macrocell.v
// One macrocell: ten product terms, fixed OR, programmable register and
// output and feedback selection.
// Assumes sampled literals and a one-cycle rising-edge enable for its clock.
`timescale 1ns/1ps
`include "slm_defs.vh"

module slm_macrocell #(
	parameter AND_W = 40
) (
	input  wire                                clk_i,
	input  wire                                rst_i,
	input  wire                                clr_all_i,
	input  wire [AND_W-1:0]                    lit_i,
	input  wire [`SLM_PT_PER_MC*AND_W-1:0]     mask_i,
	input  wire [`SLM_CFG_W-1:0]               cfg_i,
	input  wire                                pin_i,
	input  wire                                sync_rise_i,
	output wire                                q_o,
	output wire                                pin_val_o,
	output wire                                oe_o,
	output wire                                fb_o
);

	// ------------------------------------------------------------------
	// Product terms and sums
	// ------------------------------------------------------------------
	wire [`SLM_PT_PER_MC-1:0] term;
	genvar t;
	generate
		for (t = 0; t < `SLM_PT_PER_MC; t = t + 1) begin : g_pt
			// Open connections are don't-care; both literals kept give false.
			assign term[t] = &(lit_i | ~mask_i[t*AND_W +: AND_W]);
		end
	endgenerate

	wire [7:0] split  = cfg_i[`SLM_CFG_SPLIT_LSB +: 8];
	wire [1:0] typ    = cfg_i[`SLM_CFG_TYPE_LSB +: 2];
	wire [1:0] osel   = cfg_i[`SLM_CFG_OSEL_LSB +: 2];
	wire [1:0] fsel   = cfg_i[`SLM_CFG_FSEL_LSB +: 2];
	wire       inv    = cfg_i[`SLM_CFG_INV_BIT];
	wire       oinv   = cfg_i[`SLM_CFG_OINV_BIT];
	wire       mode1  = cfg_i[`SLM_CFG_MODE_BIT];
	wire       two_in = (typ == `SLM_TYPE_JK) || (typ == `SLM_TYPE_SR);

	// D and T use all eight terms; JK and SR share them between two sums.
	wire [7:0] a_terms = two_in ? (term[7:0] & ~split) : term[7:0];
	wire       sum_a   = (|a_terms) ^ inv;
	wire       sum_b   = (|(term[7:0] & split)) ^ inv;

	// ------------------------------------------------------------------
	// Register
	// ------------------------------------------------------------------
	function next_q;
		input [1:0] kind;
		input       a;
		input       b;
		input       q;
		begin
			case (kind)
				`SLM_TYPE_D:  next_q = a;
				`SLM_TYPE_T:  next_q = q ^ a;
				`SLM_TYPE_JK: next_q = (a & ~q) | (~b & q);
				`SLM_TYPE_SR: next_q = a | (~b & q);
				default:      next_q = q;
			endcase
		end
	endfunction

	reg  q_q;
	reg  ptclk_q;
	wire pt_rise = term[`SLM_PT_OECLK] & ~ptclk_q;
	wire clk_en  = mode1 ? pt_rise : sync_rise_i;

	always @(posedge clk_i) begin
		ptclk_q <= rst_i ? 1'b0 : term[`SLM_PT_OECLK];
		if (rst_i || clr_all_i || term[`SLM_PT_CLEAR]) begin
			q_q <= 1'b0;
		end else if (clk_en) begin
			q_q <= next_q(typ, sum_a, sum_b, q_q);
		end
	end

	// ------------------------------------------------------------------
	// Output and feedback
	// ------------------------------------------------------------------
	wire sel_val = (osel == `SLM_OSEL_REG) ? q_q : sum_a;

	assign q_o       = q_q;
	assign pin_val_o = sel_val ^ oinv;
	assign oe_o      = (osel == `SLM_OSEL_NONE) ? 1'b0 :
	                   (mode1 ? 1'b1 : term[`SLM_PT_OECLK]);
	assign fb_o      = (fsel == `SLM_FSEL_PIN)  ? pin_i :
	                   (fsel == `SLM_FSEL_REG)  ? q_q   :
	                   (fsel == `SLM_FSEL_COMB) ? sum_a : 1'b0;

endmodule

//--- rtl/slm_logic_array.v
// Top of the sum-of-products logic array: pin sampling, AND-plane literals,
// one macrocell per I/O pin, and a classic Wishbone register slave.
// Assumes all pins synchronous to clk_i and configuration held static.
//
// Contract
// - Small variant: four inputs, sixteen I/O pins.
// - Two synchronous clock input pins.
// - Large variant: twelve inputs, twenty-four I/O.
// - One macrocell and register per I/O pin.
// - Small: forty plane inputs, one hundred sixty terms.
// - Large: seventy-two inputs, two hundred forty terms.
// - Plane takes true and inverted pin signals.
// - Logic is programmable AND into fixed OR.
// - Register type D, T, SR or JK.
// - Product-term clock from any plane signal.
// - Output and feedback selectable with polarity.
// - Security setting blocks configuration readout.
// - Ten terms: eight sum, clear, enable/clock.
// - Clear term and reset zero the register.
// - Rising edge; first clock left, second right.
// - Three-state drives only while enable true.
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "slm_defs.vh"

module slm_logic_array #(
	parameter N_DED = `SLM_DED_SMALL,
	parameter N_IO  = `SLM_IO_SMALL,
	parameter AND_W = 2 * (N_DED + N_IO),
	parameter N_PT  = N_IO * `SLM_PT_PER_MC,
	parameter MSK_W = N_PT * AND_W
) (
	input  wire                       clk_i,
	input  wire                       rst_i,
	input  wire [N_DED-1:0]           ded_i,
	input  wire                       left_half_sync_clock_i,
	input  wire                       right_half_sync_clock_i,
	input  wire [N_IO-1:0]            io_i,
	output reg  [N_IO-1:0]            io_o,
	output reg  [N_IO-1:0]            io_oe_o,
	input  wire [MSK_W-1:0]           and_mask_i,
	input  wire [N_IO*`SLM_CFG_W-1:0] cell_cfg_i,
	input  wire                       security_i,
	input  wire                       wb_cyc_i,
	input  wire                       wb_stb_i,
	input  wire                       wb_we_i,
	input  wire [7:0]                 wb_adr_i,
	input  wire [3:0]                 wb_sel_i,
	input  wire [31:0]                wb_dat_i,
	output reg  [31:0]                wb_dat_o,
	output reg                        wb_ack_o
);

	localparam MSK_WORDS = (MSK_W + 31) / 32;
	localparam MSK_PAD   = MSK_WORDS * 32;
	localparam N_LEFT    = N_IO / 2;

	// ------------------------------------------------------------------
	// Pin sampling and clock edges
	// ------------------------------------------------------------------
	reg  [N_DED-1:0] ded_q;
	reg  [N_IO-1:0]  pin_q;
	reg  [N_IO-1:0]  fb_q;
	reg              lclk_q;
	reg              lclk_prev_q;
	reg              rclk_q;
	reg              rclk_prev_q;
	reg              clr_all_q;
	reg  [15:0]      cfg_idx_q;

	// Sync clock pins are sampled; a rising edge becomes a one-cycle enable.
	wire left_rise  = lclk_q & ~lclk_prev_q;
	wire right_rise = rclk_q & ~rclk_prev_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			ded_q       <= {N_DED{1'b0}};
			pin_q       <= {N_IO{1'b0}};
			lclk_q      <= 1'b0;
			lclk_prev_q <= 1'b0;
			rclk_q      <= 1'b0;
			rclk_prev_q <= 1'b0;
		end else begin
			ded_q       <= ded_i;
			pin_q       <= io_i;
			lclk_q      <= left_half_sync_clock_i;
			lclk_prev_q <= lclk_q;
			rclk_q      <= right_half_sync_clock_i;
			rclk_prev_q <= rclk_q;
		end
	end

	// ------------------------------------------------------------------
	// AND-plane literals
	// ------------------------------------------------------------------
	// Feedback enters the plane through fb_q, one cycle late, so that a
	// combinatorial feedback path can never close a zero-delay loop.
	wire [N_DED+N_IO-1:0] plane_sig = {fb_q, ded_q};
	wire [AND_W-1:0]      lit;
	genvar k;
	generate
		for (k = 0; k < N_DED + N_IO; k = k + 1) begin : g_lit
			assign lit[2*k]   = plane_sig[k];
			assign lit[2*k+1] = ~plane_sig[k];
		end
	endgenerate

	// ------------------------------------------------------------------
	// Macrocells
	// ------------------------------------------------------------------
	wire [N_IO-1:0] mc_q;
	wire [N_IO-1:0] mc_val;
	wire [N_IO-1:0] mc_oe;
	wire [N_IO-1:0] mc_fb;

	genvar m;
	generate
		for (m = 0; m < N_IO; m = m + 1) begin : g_mc
			// Each cell owns its own slice of ten term masks.
			slm_macrocell #(
				.AND_W(AND_W)
			) u_mc (
				.clk_i      (clk_i),
				.rst_i      (rst_i),
				.clr_all_i  (clr_all_q),
				.lit_i      (lit),
				.mask_i     (and_mask_i[m*`SLM_PT_PER_MC*AND_W +:
				                        `SLM_PT_PER_MC*AND_W]),
				.cfg_i      (cell_cfg_i[m*`SLM_CFG_W +: `SLM_CFG_W]),
				.pin_i      (pin_q[m]),
				.sync_rise_i((m < N_LEFT) ? left_rise : right_rise),
				.q_o        (mc_q[m]),
				.pin_val_o  (mc_val[m]),
				.oe_o       (mc_oe[m]),
				.fb_o       (mc_fb[m])
			);
		end
	endgenerate

	// Pins and feedback are registered so every top output is a flip-flop.
	always @(posedge clk_i) begin
		if (rst_i) begin
			io_o    <= {N_IO{1'b0}};
			io_oe_o <= {N_IO{1'b0}};
			fb_q    <= {N_IO{1'b0}};
		end else begin
			io_o    <= mc_val;
			io_oe_o <= mc_oe;
			fb_q    <= mc_fb;
		end
	end

	// ------------------------------------------------------------------
	// Configuration readback
	// ------------------------------------------------------------------
	wire [MSK_PAD-1:0] mask_pad = {{(MSK_PAD-MSK_W){1'b0}}, and_mask_i};

	reg [31:0] cfg_word;
	reg [31:0] mask_word;
	always @* begin
		cfg_word  = 32'h0000_0000;
		mask_word = 32'h0000_0000;
		// A secured part reads back nothing but zeros for configuration and masks.
		if (!security_i) begin
			if (cfg_idx_q < N_IO) begin
				cfg_word[`SLM_CFG_W-1:0] = cell_cfg_i[cfg_idx_q*`SLM_CFG_W +: `SLM_CFG_W];
			end
			if (cfg_idx_q < MSK_WORDS) begin
				mask_word = mask_pad[cfg_idx_q*32 +: 32];
			end
		end
	end

	// ------------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------------
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// A write lands at the edge where the master sees ack, not when it is taken.
	wire wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

	reg [31:0] rd_data;
	always @* begin
		rd_data = 32'h0000_0000;
		case (wb_adr_i)
			`SLM_ADR_CTRL:      rd_data[0] = clr_all_q;
			`SLM_ADR_PIN_IN:    rd_data[N_IO-1:0] = pin_q;
			`SLM_ADR_DED_IN:    rd_data[N_DED-1:0] = ded_q;
			`SLM_ADR_REG_STATE: rd_data[N_IO-1:0] = mc_q;
			`SLM_ADR_CFG_INDEX: rd_data[15:0] = cfg_idx_q;
			`SLM_ADR_CFG_DATA:  rd_data = cfg_word;
			`SLM_ADR_MASK_DATA: rd_data = mask_word;
			`SLM_ADR_STATUS:    rd_data[0] = security_i;
			default:            rd_data = 32'h0000_0000;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o  <= 1'b0;
			wb_dat_o  <= 32'h0000_0000;
			clr_all_q <= `SLM_CTRL_RESET;
			cfg_idx_q <= `SLM_INDEX_RESET;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= (req && !wb_we_i) ? rd_data : 32'h0000_0000;
			if (wr && wb_adr_i == `SLM_ADR_CTRL && wb_sel_i[0]) begin
				clr_all_q <= wb_dat_i[0];
			end
			if (wr && wb_adr_i == `SLM_ADR_CFG_INDEX) begin
				if (wb_sel_i[0]) begin
					cfg_idx_q[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					cfg_idx_q[15:8] <= wb_dat_i[15:8];
				end
			end
		end
	end

endmodule

//--- sim/slm_board.sv
// Board model: resolves every I/O pin from the array's drive and enable.
// Assumes the bench drives the dedicated inputs and clocks itself.
`timescale 1ns/1ps

module slm_board #(
	parameter N_IO = 16
) (
	input  wire            clk_i,
	input  wire [N_IO-1:0] drv_i,
	input  wire [N_IO-1:0] drv_en_i,
	output wire [N_IO-1:0] pin_o
);
	reg [N_IO-1:0] float_q = {N_IO{1'b0}};

	// A released pin keeps no level, so it toggles to expose stale reads.
	always @(posedge clk_i) begin
		float_q <= ~float_q;
	end
	assign pin_o = (drv_en_i & drv_i) | (~drv_en_i & float_q);
endmodule

//--- sim/slm_logic_array_assertions.sv
// Checker for the array top: bus handshake, reset, drive and readback.
// Assumes it is bound to slm_logic_array and sees only its ports.
`timescale 1ns/1ps
`include "slm_defs.vh"

module slm_logic_array_assertions #(
	parameter N_IO = 16
) (
	input wire                 clk_i,
	input wire                 rst_i,
	input wire [N_IO-1:0]      io_o,
	input wire [N_IO-1:0]      io_oe_o,
	input wire [N_IO*16-1:0]   cell_cfg_i,
	input wire                 security_i,
	input wire                 wb_cyc_i,
	input wire                 wb_stb_i,
	input wire                 wb_we_i,
	input wire [7:0]           wb_adr_i,
	input wire [31:0]          wb_dat_o,
	input wire                 wb_ack_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	idle_data_a: assert property (!(wb_ack_o && !wb_we_i) |-> wb_dat_o == 32'h0)
		else $error("data outside read");
	status_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `SLM_ADR_STATUS
		|-> wb_dat_o == {31'h0, security_i}) else $error("status wrong");
	secure_hide_a: assert property (wb_ack_o && !wb_we_i && security_i &&
		(wb_adr_i == `SLM_ADR_CFG_DATA || wb_adr_i == `SLM_ADR_MASK_DATA)
		|-> wb_dat_o == 32'h0) else $error("secured data leaked");
	unmapped_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h1c
		|-> wb_dat_o == 32'h0) else $error("unmapped read nonzero");
	reset_quiet_a: assert property ($past(rst_i) |-> io_o == 0 && io_oe_o == 0
		&& !wb_ack_o) else $error("outputs active after reset");
	always_drive_a: assert property (!$past(rst_i) && cell_cfg_i[8] &&
		cell_cfg_i[3:2] != 2'h0 |-> io_oe_o[0]) else $error("cell 0 not driven");
endmodule

bind slm_logic_array slm_logic_array_assertions #(.N_IO(N_IO)) u_chk (.clk_i(clk_i),
	.rst_i(rst_i), .io_o(io_o), .io_oe_o(io_oe_o), .cell_cfg_i(cell_cfg_i),
	.security_i(security_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

//--- sim/slm_logic_array_tb.sv
// Self-checking bench for the small array against a behavioural model.
// Assumes the board model resolves pins and the checker is bound.
`timescale 1ns/1ps
`include "slm_defs.vh"

module slm_logic_array_tb;
	reg           clk_i = 1'b0;
	reg           rst_i = 1'b1;
	reg  [3:0]    ded_q = 4'h0;
	reg           lclk_q = 1'b0;
	reg           rclk_q = 1'b0;
	reg           sec_q = 1'b0;
	reg           cyc_q = 1'b0;
	reg           we_q = 1'b0;
	reg  [7:0]    adr_q = 8'h00;
	reg  [31:0]   wdat_q = 32'h0;
	reg  [6399:0] mask_q;
	reg  [255:0]  cfg_q = 256'h0;
	wire [15:0]   io_o;
	wire [15:0]   io_oe;
	wire [15:0]   pin;
	wire [31:0]   rdat;
	wire          ack;
	integer       num_errors = 0;
	integer       cmp_count = 0;
	integer       r1 = 0, r2 = 0, r5 = 0, r6 = 0, r8 = 0, i, k;
	reg  [31:0]   rd;
	reg  [15:0]   ev;
	reg  [15:0]   en;

	always #20 clk_i = ~clk_i;

	slm_board u_board (.clk_i(clk_i), .drv_i(io_o), .drv_en_i(io_oe), .pin_o(pin));
	slm_logic_array u_dut (.clk_i(clk_i), .rst_i(rst_i), .ded_i(ded_q),
		.left_half_sync_clock_i(lclk_q), .right_half_sync_clock_i(rclk_q), .io_i(pin),
		.io_o(io_o), .io_oe_o(io_oe), .and_mask_i(mask_q), .cell_cfg_i(cfg_q),
		.security_i(sec_q), .wb_cyc_i(cyc_q), .wb_stb_i(cyc_q), .wb_we_i(we_q),
		.wb_adr_i(adr_q), .wb_sel_i(4'hf), .wb_dat_i(wdat_q), .wb_dat_o(rdat),
		.wb_ack_o(ack));

	// ----------------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------------
	task wrap_up;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
			if (num_errors == 0 && cmp_count > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask

	task chk_bus(input [31:0] got, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	task chk_pin(input [15:0] got, input [15:0] exp);
		chk_bus({16'h0, got}, {16'h0, exp});
	endtask

	// The request stands until ack is sampled, then drops for a cycle.
	task wb(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			n = 0;
			@(posedge clk_i);
			cyc_q <= 1'b1;
			we_q <= w;
			adr_q <= a;
			wdat_q <= d;
			@(posedge clk_i);
			while (ack !== 1'b1 && n < 20) begin
				n = n + 1;
				@(posedge clk_i);
			end
			rd = rdat;
			cyc_q <= 1'b0;
			if (n == 20) begin
				num_errors = num_errors + 1;
				wrap_up;
			end
		end
	endtask

	// High and low for several cycles so the sampled edge is seen.
	task pulse(input right);
		begin
			@(posedge clk_i);
			if (right) rclk_q <= 1'b1; else lclk_q <= 1'b1;
			repeat (3) @(posedge clk_i);
			rclk_q <= 1'b0;
			lclk_q <= 1'b0;
			repeat (5) @(posedge clk_i);
		end
	endtask

	task term(input integer m, input integer t, input [39:0] v);
		mask_q[(m*10+t)*40 +: 40] = v;
	endtask

	// ----------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------
	initial begin
		k = $urandom(32'h8b8884d4);
		// Both literals of one signal make a term false; unused terms stay so.
		for (k = 0; k < 160; k = k + 1) mask_q[k*40 +: 40] = 40'h3;
		for (k = 0; k < 5; k = k + 1) term(k, 0, 40'h1);
		term(2, 9, 40'h40);
		for (k = 1; k < 9; k = k + 1) if (k == 1 || k == 5 || k == 6 || k == 8) begin
			term(k, 0, k == 5 ? 40'h0 : 40'h4);
			term(k, 8, 40'h10);
			term(k, 9, k == 6 ? 40'h40 : 40'h0);
		end
		cfg_q[127:0] = 128'h0108_0009_0144_0184_0004_0008_0104;
		cfg_q[143:128] = 16'h0008;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 24; i = i + 1) begin
			k = $urandom;
			@(posedge clk_i);
			ded_q <= {1'b0, k[2:0]};
			if (k[2]) begin r1 = 0; r5 = 0; r6 = 0; r8 = 0; end
			repeat (5) @(posedge clk_i);
			ded_q <= k[3:0];
			if (k[3] && !k[2]) r6 = k[1];
			repeat (6) @(posedge clk_i);
			if (k[4]) begin
				pulse(0);
				r1 = k[2] ? 0 : k[1];
				r5 = k[2] ? 0 : 1 - r5;
				r2 = k[0];
			end
			if (k[5]) begin
				pulse(1);
				r8 = k[2] ? 0 : k[1];
			end
			ev = {7'h0, r8[0], 1'b0, r6[0], r5[0], ~k[0], ~k[0], k[0], r1[0], k[0]};
			en = 16'h017b | {13'h0, k[3], 2'h0};
			chk_pin(io_o & en, ev & en);
			chk_pin(io_oe, en);
			wb(0, `SLM_ADR_REG_STATE, 0);
			chk_bus(rd, {23'h0, r8[0], 1'b0, r6[0], r5[0], 2'h0, r2[0], r1[0], 1'b0});
			wb(0, `SLM_ADR_DED_IN, 0);
			chk_bus(rd, {28'h0, k[3:0]});
			// Only pins that are always driven have a known level to read back.
			wb(0, `SLM_ADR_PIN_IN, 0);
			chk_bus(rd & 32'h017b, {16'h0, ev & 16'h017b});
		end
		wb(1, `SLM_ADR_CTRL, 1);
		wb(0, `SLM_ADR_CTRL, 0);
		chk_bus(rd, 32'h1);
		wb(0, `SLM_ADR_REG_STATE, 0);
		chk_bus(rd, 32'h0);
		wb(1, `SLM_ADR_CTRL, 0);
		wb(1, `SLM_ADR_CFG_INDEX, 1);
		wb(0, `SLM_ADR_CFG_DATA, 0);
		chk_bus(rd, 32'h0008);
		wb(1, `SLM_ADR_CFG_INDEX, 16);
		wb(0, `SLM_ADR_CFG_DATA, 0);
		chk_bus(rd, 32'h0);
		wb(1, `SLM_ADR_STATUS, 32'hffff_ffff);
		wb(0, `SLM_ADR_STATUS, 0);
		chk_bus(rd, 32'h0);
		wb(0, 8'h40, 0);
		chk_bus(rd, 32'h0);
		sec_q <= 1'b1;
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1, `SLM_ADR_CFG_INDEX, 1);
		wb(0, `SLM_ADR_CFG_DATA, 0);
		chk_bus(rd, 32'h0);
		wb(0, `SLM_ADR_MASK_DATA, 0);
		chk_bus(rd, 32'h0);
		wb(0, `SLM_ADR_STATUS, 0);
		chk_bus(rd, 32'h1);
		wrap_up;
	end
endmodule
